// [hdl/scch_top.sv]
/*
 * Sensor configuration command handler: setting commands, addressing,
 * ring forwarding and sample pacing, with an Avalon-MM register slave.
 * Assumes the command framing is parsed outside; software writes ARG,
 * then CMD, and reads the forwarded ring message from FWD.
 */
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
// What this block does
// - High limit stored as 50 mV counts and read back unchanged.
// - High limit zero means full 5 V span.
// - High limit above 100 is stored as 100.
// - Bad argument sets the error flag and keeps the setting.
// - High limit not above low limit is refused with an error.
// - Rate form n gives n readings per second.
// - Period form n gives one reading every n times 100 ms.
// - Integration argument zero restores the saved setting.
// - Rate form ignores speed shift and idle count.
// - Reset integration is period form, argument 2.
// - Idle count k outputs one of every k plus one readings.
// - Idle count applies only in period form without speed shift.
// - Watchdog option refuses nonzero idle count with an error.
// - Ring id 00 nulls own address, forwards unchanged.
// - Ring id 01 to 88 becomes address, forwarded plus one.
// - Ring id 89 becomes address, forwarded as 99.
// - Ring id 90 to 98 sets group, forwarded unchanged.
// - Ring id 99 forwards error marker; marker forwarded unchanged.
// - Null-address bus unit ignores group and global commands, except serial selection, and enable and id once serial-selected.
// - Bus id broadcast needs prior matching serial-number selection.
// - Four-digit bus id sets group and sub-address.
`timescale 1ns/1ps
`default_nettype none
module scch_top #(
    parameter int STEP_CYCLES = scch_pkg::STEP_CYC,
    parameter int CLK_RATE_HZ = scch_pkg::CLK_HZ
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Pacing
    input wire logic speed_shift_i,
    output logic sample_o,
    output logic output_o,
    // Ring forward and analog level
    output logic fwd_valid_o,
    output logic [13:0] fwd_value_o,
    output logic fwd_err_o,
    output logic [6:0] high_level_o
);
    // Bus handshake: every access answers on the second edge
    logic ack_reg;
    logic [31:0] rdata_reg;
    wire logic req = avs_read_i | avs_write_i;
    wire logic acc = req & ack_reg;
    assign avs_waitrequest_o = req & ~ack_reg;
    assign avs_readdata_o = rdata_reg;

    // Software-visible state
    logic [31:0] arg_reg, serial_reg, cfg_reg;
    logic err_reg, we_reg, sel_reg;
    logic [6:0] high_reg, integ_n_reg, saved_n_reg;
    logic integ_rate_reg, saved_rate_reg;
    logic [7:0] idle_reg, addr_reg, group_reg, sub_reg;
    logic fwd_valid_reg, fwd_err_reg;
    logic [13:0] fwd_value_reg;

    // Command decode
    wire logic cmd_go = acc & avs_write_i & avs_address_i == scch_pkg::OFS_CMD;
    wire logic [3:0] op = avs_writedata_i[scch_pkg::CMD_OP_LSB +: 4];
    wire logic [7:0] dest = avs_writedata_i[scch_pkg::CMD_DEST_LSB +: 8];
    wire logic wide = avs_writedata_i[scch_pkg::CMD_WIDE_BIT];
    wire logic errmk = avs_writedata_i[scch_pkg::CMD_ERRMK_BIT];
    wire logic badarg = avs_writedata_i[scch_pkg::CMD_BADARG_BIT];
    wire logic [13:0] arg = arg_reg[13:0];
    wire logic [6:0] arg7 = arg_reg[6:0];
    wire logic arg_hi = |arg_reg[31:7];
    wire logic multidrop = cfg_reg[scch_pkg::CFG_MULTIDROP_BIT];
    wire logic watchdog = cfg_reg[scch_pkg::CFG_WATCHDOG_BIT];
    wire logic [6:0] low_lim = cfg_reg[scch_pkg::CFG_LOW_LSB +: 7];
    wire logic [31:0] wdata = avs_writedata_i;

    // Addressing: own, group, global
    wire logic to_group = dest >= scch_pkg::ADDR_GROUP_LO;
    wire logic to_me = (dest == addr_reg) | (to_group & (dest == group_reg
        | dest == scch_pkg::ADDR_GLOBAL));
    wire logic null_unit = addr_reg == scch_pkg::ADDR_NULL;
    wire logic md_null_block = multidrop & null_unit & to_group;
    wire logic is_id = op == scch_pkg::OP_UNIT_ADDR;
    wire logic is_ser = op == scch_pkg::OP_SERIAL_SEL;
    wire logic is_we = op == scch_pkg::OP_WRITE_EN;
    // Selected bus units still take the broadcast enable and id
    wire logic md_sel_ok = multidrop & to_group & sel_reg & (is_we | is_id);
    wire logic md_id_block = multidrop & is_id & to_group & ~sel_reg;
    wire logic ring_id = ~multidrop & is_id;
    wire logic addressed = ring_id | is_ser | md_sel_ok
        | (to_me & ~md_null_block & ~md_id_block);
    wire logic setting = ~is_we & ~is_ser & ~ring_id;
    wire logic exec = cmd_go & addressed & (~setting | we_reg);

    // Argument checks: high limit, integration, idle count
    wire logic [6:0] high_clamp = arg_hi | (arg7 > scch_pkg::HIGH_MAX)
        ? scch_pkg::HIGH_MAX : arg7;
    wire logic [6:0] high_eff = (high_clamp == 7'h00)
        ? scch_pkg::HIGH_MAX : high_clamp;
    wire logic high_bad = badarg | (high_eff <= low_lim);
    wire logic integ_bad = badarg | arg_hi | (arg7 > scch_pkg::INTEG_MAX);
    wire logic idle_bad = badarg | (|arg_reg[31:8])
        | (watchdog & (|arg_reg[7:0]));

    // Bus unit id: two-digit address or four-digit group and sub
    wire logic [13:0] grp14 = arg / 14'd100;
    wire logic [13:0] sub14 = arg - grp14 * 14'd100;
    wire logic md_id_bad = badarg | errmk | (wide ? (grp14 < 14'd90
        | grp14 > 14'd98 | sub14 == 14'd0) : (arg >= 14'd90));

    // Ring id: new address, new group, forwarded value
    wire logic [7:0] id8 = arg[7:0];
    wire logic ring_bad = badarg | wide | (arg >= scch_pkg::ARG_TWO_DIGIT_LIM);
    wire logic r_seq = ~errmk & id8 >= 8'h01 & id8 <= scch_pkg::ADDR_LAST_SEQ;
    wire logic r_end = ~errmk & (id8 == scch_pkg::ADDR_RING_END);
    wire logic r_grp = ~errmk & (id8 >= scch_pkg::ADDR_GROUP_LO)
        & (id8 < scch_pkg::ADDR_GLOBAL);
    wire logic r_null = ~errmk & (id8 == scch_pkg::ADDR_NULL);
    wire logic r_glob = ~errmk & (id8 == scch_pkg::ADDR_GLOBAL);
    wire logic [13:0] ring_fwd = r_seq ? arg + 14'd1
        : r_end ? 14'd99 : arg;
    wire logic ring_fwd_err = errmk | r_glob;

    wire logic cmd_err = exec & (
        (op == scch_pkg::OP_HIGH_LIMIT & high_bad)
        | ((op == scch_pkg::OP_INTEG_RATE | op == scch_pkg::OP_INTEG_PERIOD)
            & integ_bad)
        | (op == scch_pkg::OP_IDLE_COUNT & idle_bad)
        | (is_id & (multidrop ? md_id_bad : ring_bad)));
    wire logic status_rd = acc & avs_read_i
        & (avs_address_i == scch_pkg::OFS_STATUS);

    // Read mux, unmapped words read zero
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (avs_address_i)
            scch_pkg::OFS_ARG: rmux = arg_reg;
            scch_pkg::OFS_STATUS: rmux = {16'h0000, addr_reg, 5'h00,
                sel_reg, we_reg, err_reg};
            scch_pkg::OFS_SETTINGS: rmux = {8'h00, idle_reg,
                integ_rate_reg, integ_n_reg, 1'b0, high_reg};
            scch_pkg::OFS_CONFIG: rmux = cfg_reg;
            scch_pkg::OFS_SERIAL: rmux = serial_reg;
            scch_pkg::OFS_ADDR: rmux = {7'h00, sel_reg, sub_reg,
                group_reg, addr_reg};
            scch_pkg::OFS_FWD: rmux = {14'h0000, fwd_valid_reg,
                fwd_err_reg, 2'b00, fwd_value_reg};
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg)
                rdata_reg <= avs_read_i ? rmux : 32'h0000_0000;
        end
    end

    // Plain software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arg_reg <= 32'h0000_0000;
            cfg_reg <= 32'h0000_0000;
            serial_reg <= 32'h0000_0000;
        end else if (acc & avs_write_i) begin
            if (avs_address_i == scch_pkg::OFS_ARG)
                arg_reg <= wdata;
            if (avs_address_i == scch_pkg::OFS_CONFIG)
                cfg_reg <= {16'h0000, 1'b0, wdata[14:8], 6'h00, wdata[1:0]};
            if (avs_address_i == scch_pkg::OFS_SERIAL)
                serial_reg <= wdata;
        end
    end

    // Error flag: a new error wins over the clearing read
    always_ff @(posedge clk_i) begin
        if (rst_i)
            err_reg <= 1'b0;
        else if (cmd_err)
            err_reg <= 1'b1;
        else if (status_rd)
            err_reg <= 1'b0;
    end

    // Write enable and serial selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            we_reg <= 1'b0;
            sel_reg <= 1'b0;
        end else if (cmd_go & addressed) begin
            we_reg <= is_we;
            if (is_ser & multidrop)
                sel_reg <= (serial_reg == arg_reg);
            else if (is_id & exec)
                sel_reg <= 1'b0;
        end
    end

    // Setting commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_reg <= scch_pkg::RST_HIGH;
            integ_n_reg <= scch_pkg::RST_INTEG_N;
            integ_rate_reg <= scch_pkg::RST_INTEG_RATE;
            saved_n_reg <= scch_pkg::RST_INTEG_N;
            saved_rate_reg <= scch_pkg::RST_INTEG_RATE;
            idle_reg <= scch_pkg::RST_IDLE;
        end else if (exec & ~cmd_err) begin
            unique case (op)
                scch_pkg::OP_HIGH_LIMIT: high_reg <= high_clamp;
                scch_pkg::OP_INTEG_RATE,
                scch_pkg::OP_INTEG_PERIOD: begin
                    if (arg7 == 7'h00) begin
                        integ_n_reg <= saved_n_reg;
                        integ_rate_reg <= saved_rate_reg;
                    end else begin
                        integ_n_reg <= arg7;
                        integ_rate_reg <= op == scch_pkg::OP_INTEG_RATE;
                    end
                end
                scch_pkg::OP_IDLE_COUNT: idle_reg <= arg_reg[7:0];
                scch_pkg::OP_SAVE_ALL: begin
                    saved_n_reg <= integ_n_reg;
                    saved_rate_reg <= integ_rate_reg;
                end
                default: ;
            endcase
        end
    end

    // Unit addressing and the ring forward message
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= scch_pkg::ADDR_NULL;
            group_reg <= scch_pkg::RST_GROUP;
            sub_reg <= 8'h00;
            fwd_valid_reg <= 1'b0;
            fwd_err_reg <= 1'b0;
            fwd_value_reg <= 14'h0000;
        end else begin
            fwd_valid_reg <= 1'b0;
            if (exec & ring_id) begin
                fwd_valid_reg <= 1'b1;
                fwd_err_reg <= cmd_err ? errmk : ring_fwd_err;
                fwd_value_reg <= cmd_err ? arg : ring_fwd;
                if (~cmd_err & (r_null | r_seq | r_end))
                    addr_reg <= id8;
                if (~cmd_err & r_grp)
                    group_reg <= id8;
            end
            if (exec & ~ring_id & is_id & ~cmd_err) begin
                if (wide) begin
                    group_reg <= grp14[7:0];
                    sub_reg <= sub14[7:0];
                end else begin
                    addr_reg <= arg[7:0];
                end
            end
        end
    end

    // Sample pacing: 100 ms step enable and rate accumulator
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);
    localparam logic [31:0] RATE_DIV = 32'(CLK_RATE_HZ);
    logic [SW-1:0] step_cnt_reg;
    logic [6:0] per_cnt_reg;
    logic [31:0] rate_acc_reg;
    logic [7:0] idle_cnt_reg;
    logic sample_reg, output_reg;
    wire logic step_en = step_cnt_reg == STEP_LAST;
    wire logic [31:0] acc_sum = rate_acc_reg + {25'h0, integ_n_reg};
    wire logic rate_tick = acc_sum >= RATE_DIV;
    // Speed shift shortens the period to one step, period form only
    wire logic [6:0] per_len = speed_shift_i ? 7'h01 : integ_n_reg;
    wire logic per_tick = step_en & (per_cnt_reg + 7'h01 >= per_len);
    wire logic tick = integ_rate_reg ? rate_tick : per_tick;
    wire logic use_idle = ~integ_rate_reg & ~speed_shift_i;
    wire logic idle_done = ~use_idle | (idle_cnt_reg >= idle_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_cnt_reg <= '0;
            per_cnt_reg <= 7'h00;
            rate_acc_reg <= 32'h0000_0000;
            idle_cnt_reg <= 8'h00;
            sample_reg <= 1'b0;
            output_reg <= 1'b0;
        end else begin
            step_cnt_reg <= step_en ? '0 : step_cnt_reg + SW'(1);
            if (step_en)
                per_cnt_reg <= per_tick ? 7'h00 : per_cnt_reg + 7'h01;
            rate_acc_reg <= rate_tick ? acc_sum - RATE_DIV : acc_sum;
            sample_reg <= tick;
            output_reg <= tick & idle_done;
            if (tick)
                idle_cnt_reg <= idle_done ? 8'h00 : idle_cnt_reg + 8'h01;
        end
    end

    assign sample_o = sample_reg;
    assign output_o = output_reg;
    assign fwd_valid_o = fwd_valid_reg;
    assign fwd_value_o = fwd_value_reg;
    assign fwd_err_o = fwd_err_reg;
    assign high_level_o = (high_reg == 7'h00) ? scch_pkg::HIGH_MAX : high_reg;

    // Checks
    property p_high_clamp;
        @(posedge clk_i) disable iff (rst_i)
        exec & ~cmd_err & op == scch_pkg::OP_HIGH_LIMIT
        & arg_reg > 32'h0000_0064 |=> high_reg == scch_pkg::HIGH_MAX;
    endproperty
    a_high_clamp: assert property (p_high_clamp)
        else $error("high limit not clamped");
    property p_high_zero;
        @(posedge clk_i) disable iff (rst_i)
        high_reg == 7'h00 |-> high_level_o == 7'd100;
    endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("zero high limit not full span");
    property p_err_keeps;
        @(posedge clk_i) disable iff (rst_i)
        cmd_err |=> err_reg && $stable(high_reg) && $stable(idle_reg)
            && $stable(integ_n_reg);
    endproperty
    a_err_keeps: assert property (p_err_keeps)
        else $error("error did not flag or changed setting");
    property p_high_low;
        @(posedge clk_i) disable iff (rst_i)
        high_level_o > low_lim or $past(cfg_reg) != cfg_reg
            or $past(rst_i, 1);
    endproperty
    a_high_low: assert property (p_high_low)
        else $error("high level not above low limit");
    property p_no_enable;
        @(posedge clk_i) disable iff (rst_i)
        cmd_go & setting & ~we_reg |=> $stable(high_reg) && $stable(idle_reg);
    endproperty
    a_no_enable: assert property (p_no_enable)
        else $error("setting changed without write enable");
    property p_idle_wd;
        @(posedge clk_i) disable iff (rst_i)
        watchdog & exec & op == scch_pkg::OP_IDLE_COUNT & |arg_reg[7:0]
        |=> err_reg ##0 $stable(idle_reg);
    endproperty
    a_idle_wd: assert property (p_idle_wd)
        else $error("nonzero idle count taken under watchdog");
    property p_ring_seq;
        @(posedge clk_i) disable iff (rst_i)
        exec & ring_id & ~cmd_err & r_seq
        |=> fwd_valid_o && fwd_value_o == $past(arg) + 14'd1
            && addr_reg == $past(id8);
    endproperty
    a_ring_seq: assert property (p_ring_seq)
        else $error("ring numbering wrong");
    property p_ring_glob;
        @(posedge clk_i) disable iff (rst_i)
        exec & ring_id & ~cmd_err & r_glob |=> fwd_err_o && $stable(addr_reg);
    endproperty
    a_ring_glob: assert property (p_ring_glob)
        else $error("ring 99 not turned to marker");
    property p_err_clear;
        @(posedge clk_i) disable iff (rst_i)
        status_rd & ~cmd_err |=> ~err_reg;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flag not cleared by status read");
    property p_rate_no_idle;
        @(posedge clk_i) disable iff (rst_i)
        integ_rate_reg & tick |=> output_o;
    endproperty
    a_rate_no_idle: assert property (p_rate_no_idle)
        else $error("idle count applied in rate form");
    c_ring: cover property (@(posedge clk_i) exec & ring_id & r_end);
    c_md_wide: cover property (@(posedge clk_i)
        exec & multidrop & is_id & wide);
    c_sel: cover property (@(posedge clk_i) cmd_go & is_ser & multidrop);
    c_out: cover property (@(posedge clk_i) output_o & ~integ_rate_reg);
endmodule
`default_nettype wire

// [inc/scch_pkg.sv]
/*
 * Shared constants of the sensor configuration command handler.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
`default_nettype none
package scch_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CMD = 5'h00;
    localparam logic [4:0] OFS_ARG = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_SETTINGS = 5'h0C;
    localparam logic [4:0] OFS_CONFIG = 5'h10;
    localparam logic [4:0] OFS_SERIAL = 5'h14;
    localparam logic [4:0] OFS_ADDR = 5'h18;
    localparam logic [4:0] OFS_FWD = 5'h1C;
    // CMD word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_LSB = 8;
    localparam int CMD_WIDE_BIT = 16;
    localparam int CMD_ERRMK_BIT = 17;
    localparam int CMD_BADARG_BIT = 18;
    // CONFIG word fields
    localparam int CFG_MULTIDROP_BIT = 0;
    localparam int CFG_WATCHDOG_BIT = 1;
    localparam int CFG_LOW_LSB = 8;
    // Command opcodes
    localparam logic [3:0] OP_WRITE_EN = 4'h1;
    localparam logic [3:0] OP_HIGH_LIMIT = 4'h2;
    localparam logic [3:0] OP_INTEG_RATE = 4'h3;
    localparam logic [3:0] OP_INTEG_PERIOD = 4'h4;
    localparam logic [3:0] OP_IDLE_COUNT = 4'h5;
    localparam logic [3:0] OP_UNIT_ADDR = 4'h6;
    localparam logic [3:0] OP_SERIAL_SEL = 4'h7;
    localparam logic [3:0] OP_SAVE_ALL = 4'h8;
    // Value limits and addresses
    localparam logic [6:0] HIGH_MAX = 7'h64;
    localparam logic [6:0] INTEG_MAX = 7'h78;
    localparam logic [7:0] ADDR_NULL = 8'h00;
    localparam logic [7:0] ADDR_LAST_SEQ = 8'h58;
    localparam logic [7:0] ADDR_RING_END = 8'h59;
    localparam logic [7:0] ADDR_GROUP_LO = 8'h5A;
    localparam logic [7:0] ADDR_GLOBAL = 8'h63;
    localparam logic [13:0] ARG_TWO_DIGIT_LIM = 14'h0064;
    // Reset values
    localparam logic [6:0] RST_HIGH = 7'h64;
    localparam logic [6:0] RST_INTEG_N = 7'h02;
    localparam logic RST_INTEG_RATE = 1'b0;
    localparam logic [7:0] RST_IDLE = 8'h00;
    localparam logic [7:0] RST_GROUP = 8'h5A;
    // Timing
    localparam int CLK_HZ = 200000000;
    localparam int STEP_MS = 100;
    localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
endpackage
`default_nettype wire

// [tb/scch_ring_peer.sv]
/* Next unit on the ring: latches each forwarded id message.
   Assumes the handler's one-cycle forward pulse on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module scch_ring_peer (
    // Clock
    input wire logic clk_i,
    // Forwarded message from the handler
    input wire logic fwd_valid_i,
    input wire logic [13:0] fwd_value_i,
    input wire logic fwd_err_i,
    // Message as received, one cycle later
    output logic msg_o,
    output logic [14:0] msg_data_o
);
    always_ff @(posedge clk_i) begin
        msg_o <= fwd_valid_i;
        if (fwd_valid_i) begin
            msg_data_o <= {fwd_err_i, fwd_value_i};
        end
    end
endmodule
`default_nettype wire

// [tb/sensor_config_command_handler_tb.sv]
/* Self-checking bench of the command handler over Avalon-MM.
   Assumes short pacing: 20-cycle step, 240-cycle rate base. */
`timescale 1ns/1ps
`default_nettype none
module sensor_config_command_handler_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic speed_shift_i = 1'b0;
    logic [31:0] avs_readdata_o, m;
    logic avs_waitrequest_o, sample_o, output_o, fwd_valid_o, fwd_err_o;
    logic msg, jit = 1'b0;
    logic [13:0] fwd_value_o;
    logic [6:0] high_level_o, h;
    logic [14:0] msg_data, f;
    logic [31:0] rd_q[$], mk_q[$];
    logic [14:0] fw_q[$];
    logic [7:0] dest = 8'h00;
    integer n_fail = 0, n_compared = 0, seed = 32'h6b026d6f;
    integer n_smp = 0, n_out = 0, s0, o0, i;
    logic [13:0] id_a[7] = '{14'h0, 14'h5, 14'h58, 14'h59, 14'h5F, 14'h63,
        14'h5};
    logic [14:0] fw_e[7] = '{15'h0, 15'h6, 15'h59, 15'h63, 15'h5F, 15'h4000,
        15'h4000};
    logic [31:0] ad_e[7] = '{32'h5A00, 32'h5A05, 32'h5A58, 32'h5A59,
        32'h5F59, 32'h5F59, 32'h5F59};

    scch_top #(.STEP_CYCLES(20), .CLK_RATE_HZ(240)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .speed_shift_i(speed_shift_i),
        .sample_o(sample_o), .output_o(output_o), .fwd_valid_o(fwd_valid_o),
        .fwd_value_o(fwd_value_o), .fwd_err_o(fwd_err_o),
        .high_level_o(high_level_o));
    scch_ring_peer peer (.clk_i(clk_i), .fwd_valid_i(fwd_valid_o),
        .fwd_value_i(fwd_value_o), .fwd_err_i(fwd_err_o), .msg_o(msg),
        .msg_data_o(msg_data));

    always #2.5 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, mk);
        rd_q.push_back(e & mk);
        mk_q.push_back(mk);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cmd(input logic [3:0] op, input logic [13:0] arg,
        input logic [2:0] fl);
        bus(1'b1, scch_pkg::OFS_ARG, {18'h0, arg});
        bus(1'b1, scch_pkg::OFS_CMD, {13'h0, fl, dest, 4'h0, op});
    endtask

    task automatic set(input logic [3:0] op, input logic [13:0] arg);
        bus(1'b1, scch_pkg::OFS_CMD, {16'h0, dest, 4'h0,
            scch_pkg::OP_WRITE_EN});
        cmd(op, arg, 3'h0);
    endtask

    // Pulse counts over a window, one off allowed for phase
    task automatic pace(input integer cyc, es, eo);
        repeat (100) @(posedge clk_i);
        s0 = n_smp;
        o0 = n_out;
        repeat (cyc) @(posedge clk_i);
        s0 = n_smp - s0;
        o0 = n_out - o0;
        chk("samples", es, (s0 - es) * (s0 - es) <= 1 ? es : s0);
        chk("outputs", eo, (o0 - eo) * (o0 - eo) <= 1 ? eo : o0);
    endtask

    always @(posedge clk_i) begin
        n_smp <= n_smp + (sample_o === 1'b1);
        n_out <= n_out + (output_o === 1'b1);
        speed_shift_i <= jit ? 1'($random(seed)) : 1'b0;
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            m = mk_q.pop_front();
            chk("readdata", rd_q.pop_front(), avs_readdata_o & m);
        end
        if (msg === 1'b1) begin
            f = fw_q.pop_front();
            chk("forward", f, f[14] ? {msg_data[14], 14'h0} : msg_data);
        end
    end

    initial begin
        #100000;
        chk("watchdog", 32'h0, 32'h1);
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(scch_pkg::OFS_SETTINGS, 32'h264, 32'hFFFFFF);
        h = 7'(51 + ($random(seed) & 31));
        set(scch_pkg::OP_HIGH_LIMIT, {7'h0, h});
        cmd(scch_pkg::OP_HIGH_LIMIT, 14'd70, 3'h0);
        rd(scch_pkg::OFS_SETTINGS, {25'h0, h}, 32'h7F);
        set(scch_pkg::OP_HIGH_LIMIT, 14'd150);
        rd(scch_pkg::OFS_SETTINGS, 32'h64, 32'h7F);
        set(scch_pkg::OP_HIGH_LIMIT, 14'd0);
        rd(scch_pkg::OFS_SETTINGS, 32'h0, 32'h7F);
        chk("high level", 32'h64, {25'h0, high_level_o});
        bus(1'b1, scch_pkg::OFS_CONFIG, 32'h3200);
        set(scch_pkg::OP_HIGH_LIMIT, 14'd40);
        rd(scch_pkg::OFS_STATUS, 32'h1, 32'h1);
        rd(scch_pkg::OFS_STATUS, 32'h0, 32'h1);
        bus(1'b1, scch_pkg::OFS_CMD, {16'h0, dest, 4'h0, 4'h1});
        cmd(scch_pkg::OP_HIGH_LIMIT, 14'd90, 3'b100);
        rd(scch_pkg::OFS_STATUS, 32'h1, 32'h1);
        rd(scch_pkg::OFS_SETTINGS, 32'h0, 32'h7F);
        set(scch_pkg::OP_IDLE_COUNT, 14'd1);
        pace(400, 10, 5);
        set(scch_pkg::OP_INTEG_RATE, 14'd24);
        jit = 1'b1;
        pace(480, 48, 48);
        jit = 1'b0;
        rd(scch_pkg::OFS_SETTINGS, 32'h9800, 32'hFF00);
        set(scch_pkg::OP_INTEG_PERIOD, 14'd0);
        rd(scch_pkg::OFS_SETTINGS, 32'h10200, 32'hFFFF00);
        set(scch_pkg::OP_INTEG_RATE, 14'd7);
        set(scch_pkg::OP_SAVE_ALL, 14'd0);
        set(scch_pkg::OP_INTEG_PERIOD, 14'd0);
        rd(scch_pkg::OFS_SETTINGS, 32'h8700, 32'hFF00);
        set(scch_pkg::OP_INTEG_RATE, 14'd121);
        rd(scch_pkg::OFS_STATUS, 32'h1, 32'h1);
        bus(1'b1, scch_pkg::OFS_CONFIG, 32'h2);
        set(scch_pkg::OP_IDLE_COUNT, 14'd3);
        rd(scch_pkg::OFS_STATUS, 32'h1, 32'h1);
        rd(scch_pkg::OFS_SETTINGS, 32'h10000, 32'hFF0000);
        bus(1'b1, scch_pkg::OFS_CONFIG, 32'h0);
        dest = 8'h63;
        for (i = 0; i < 7; i++) begin
            fw_q.push_back(fw_e[i]);
            cmd(scch_pkg::OP_UNIT_ADDR, id_a[i],
                {1'b0, i == 6, 1'b0});
            rd(scch_pkg::OFS_ADDR, ad_e[i],
                32'hFFFF);
        end
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, scch_pkg::OFS_CONFIG, 32'h1);
        bus(1'b1, scch_pkg::OFS_SERIAL, 32'h3175);
        set(scch_pkg::OP_HIGH_LIMIT, 14'd60);
        set(scch_pkg::OP_UNIT_ADDR, 14'd7);
        rd(scch_pkg::OFS_SETTINGS, 32'h64, 32'h7F);
        rd(scch_pkg::OFS_ADDR, 32'h0, 32'hFF);
        cmd(scch_pkg::OP_SERIAL_SEL, 14'h3176, 3'h0);
        rd(scch_pkg::OFS_STATUS, 32'h0, 32'h4);
        cmd(scch_pkg::OP_SERIAL_SEL, 14'h3175, 3'h0);
        rd(scch_pkg::OFS_STATUS, 32'h4, 32'h4);
        set(scch_pkg::OP_UNIT_ADDR, 14'd2);
        rd(scch_pkg::OFS_ADDR, 32'h2, 32'hFF);
        dest = 8'h02;
        bus(1'b1, scch_pkg::OFS_CMD, {16'h0, dest, 4'h0, 4'h1});
        cmd(scch_pkg::OP_UNIT_ADDR, 14'd9101, 3'b001);
        rd(scch_pkg::OFS_ADDR, 32'h15B02, 32'hFFFFFF);
        stop_test();
    end
endmodule
`default_nettype wire
